// *** sim/adc_control_sequencer_assertions.sv ***
module adc_control_sequencer_assertions (
    input wire logic clk,
    input wire logic rst,
    input wire logic tfsN,
    input wire logic rfsN,
    input wire logic sdataOe,
    input wire logic dataReadyN,
    input wire logic convDone,
    input wire logic activeChannel,
    input wire logic [2:0] gainCode,
    input wire logic [7:0] gainFactor,
    input wire logic [11:0] filterCode,
    input wire logic filterCodeLegal,
    input wire logic filterRestart,
    input wire logic calBusy
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence ready_shown;
        ##[0:1] !dataReadyN;
    endsequence
    a_reset_state:
    assert property (disable iff (1'b0) rst |=> dataReadyN && !calBusy && !filterRestart
        && gainCode == 3'h0 && !activeChannel && filterCode == adc_ctrl_pkg::FILTER_RESET)
        else $error("reset state wrong");
    a_gain_decode:
    assert property (gainFactor == (8'h01 << gainCode)) else $error("gain factor wrong");
    a_filter_range:
    assert property (filterCodeLegal == (filterCode >= adc_ctrl_pkg::FILTER_MIN
        && filterCode <= adc_ctrl_pkg::FILTER_MAX)) else $error("filter legal flag wrong");
    // A second reset during calibration also drops the busy flag, hence the past check
    a_cal_from_conv:
    assert property ($fell(calBusy) && !$past(rst) |-> $past(convDone) || $past(convDone, 2))
        else $error("calibration ended without a conversion");
    a_cal_ready:
    assert property ($fell(calBusy) && !$past(rst) |-> ready_shown)
        else $error("no ready after calibration");
    a_oe_frame:
    assert property (sdataOe |-> !rfsN && tfsN) else $error("data driven outside read frame");
    a_restart_single:
    assert property (filterRestart |=> !filterRestart) else $error("restart longer than one");
    a_ctrl_load:
    assert property ($changed({gainCode, activeChannel, filterCode}) && !$past(rst)
        |-> $past(filterRestart) or ##[0:2] filterRestart) else $error("control moved alone");
endmodule : adc_control_sequencer_assertions

// *** sim/host_link_model.sv ***
module host_link_model (
    output logic sclk,
    output logic tfsN,
    output logic rfsN,
    output logic registerSelectLine,
    output logic sdataIn,
    input wire logic sdataOut
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam realtime HALF = 62.5;
    initial begin
        sclk = 1'b0;
        tfsN = 1'b1;
        rfsN = 1'b1;
        registerSelectLine = 1'b0;
        sdataIn = 1'b0;
    end
    // Link clock only runs inside frames
    task automatic pulse;
        sclk = 1'b1;
        #HALF;
        sclk = 1'b0;
    endtask : pulse
    task automatic write(input logic sel, input logic [23:0] w, input int n, input int extra);
        registerSelectLine = sel;
        #20;
        tfsN = 1'b0;
        for (int i = 0; i < n + extra; i++) begin
            // Data moves half a period before the rising edge, never with it
            sdataIn = (i < n) ? w[23 - i] : 1'($urandom);
            #HALF;
            pulse();
        end
        tfsN = 1'b1;
        // Released line flips so a stale bit can never look valid
        sdataIn = ~sdataIn;
        #200;
    endtask : write
    task automatic read(input logic sel, input int n, output logic [23:0] d);
        registerSelectLine = sel;
        #20;
        rfsN = 1'b0;
        d = 24'h000000;
        #HALF;
        for (int i = 0; i < n; i++) begin
            d = {d[22:0], sdataOut};
            pulse();
            #HALF;
        end
        rfsN = 1'b1;
        #200;
    endtask : read
endmodule : host_link_model

// *** sim/test_adc_control_word_calibration_sequencer.sv ***
`define CHECK(g, e) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_adc_control_word_calibration_sequencer;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, rst, convDone, sdataOut, sdataOe, dataReadyN, activeChannel, powerDown;
    logic compCurrent, burnoutCurrent, unipolar, filterCodeLegal, filterRestart, calBusy;
    logic sclk, tfsN, rfsN, registerSelectLine, sdataIn;
    logic [23:0] convRaw, w, r, zr, fr, e;
    logic [2:0] gainCode;
    logic [7:0] gainFactor;
    logic [11:0] filterCode;
    adc_ctrl_pkg::front_src_t frontSource;
    logic [31:0] got;
    logic [31:0] want;
    logic [31:0] expq[$];
    int n_errors = 0;
    int n_tests = 0;
    event seen;
    adc_control_sequencer dut_u (.clk(clk), .rst(rst), .sclk(sclk), .tfsN(tfsN), .rfsN(rfsN),
        .registerSelectLine(registerSelectLine), .sdataIn(sdataIn), .sdataOut(sdataOut),
        .sdataOe(sdataOe), .dataReadyN(dataReadyN), .convDone(convDone), .convRaw(convRaw),
        .frontSource(frontSource), .activeChannel(activeChannel), .gainCode(gainCode),
        .gainFactor(gainFactor), .powerDown(powerDown), .compCurrent(compCurrent),
        .burnoutCurrent(burnoutCurrent), .unipolar(unipolar), .filterCode(filterCode),
        .filterCodeLegal(filterCodeLegal), .filterRestart(filterRestart), .calBusy(calBusy));
    host_link_model hostU (.sclk(sclk), .tfsN(tfsN), .rfsN(rfsN), .sdataOut(sdataOut),
        .registerSelectLine(registerSelectLine), .sdataIn(sdataIn));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic results;
        $display("tests %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : results
    task automatic note(input logic [31:0] x, input logic [31:0] a);
        expq.push_back(x);
        got = a;
        ->seen;
        #1;
    endtask : note
    task automatic rd(input logic sel, input int n, input logic [23:0] x);
        logic [23:0] d;
        hostU.read(sel, n, d);
        note({8'h00, x}, {8'h00, d});
    endtask : rd
    task automatic wr(input logic sel, input logic [23:0] v, input int n, input int extra);
        hostU.write(sel, v, n, extra);
        repeat (10) @(posedge clk);
    endtask : wr
    task automatic coef(input logic [2:0] m, input logic c, input logic [23:0] x);
        wr(1'b0, {m, 3'h0, c, 5'h00, 12'h0C8}, 24, 0);
        rd(1'b1, 24, x);
    endtask : coef
    task automatic conv(input logic [23:0] v);
        @(posedge clk);
        convDone <= 1'b1;
        convRaw <= v;
        @(posedge clk);
        convDone <= 1'b0;
        convRaw <= 24'($urandom);
        repeat (4) @(posedge clk);
    endtask : conv
    function automatic logic [31:0] pk(input logic [23:0] c, input logic rdy);
        pk = {6'h00, 8'h01 << c[20:18], c[17], c[16], c[14], c[13], c[12], c[11:0], rdy};
    endfunction : pk
    function automatic logic [31:0] obs();
        obs = {6'h00, gainFactor, activeChannel, powerDown, compCurrent, burnoutCurrent,
            unipolar, filterCode, dataReadyN};
    endfunction : obs
    initial begin
        forever begin
            @(seen);
            // Popped once here: the macro names its arguments twice
            want = expq.pop_front();
            `CHECK(got, want)
        end
    end
    initial begin
        #300us;
        n_errors++;
        results();
    end
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        rst = 1'b1;
        convDone = 1'b0;
        convRaw = 24'h000000;
        void'($urandom(32'h5EAF5E71));
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        rd(1'b0, 24, adc_ctrl_pkg::CONTROL_RESET);
        note(pk(adc_ctrl_pkg::CONTROL_RESET, 1'b1), obs());
        $display("test reset done");
        for (int g = 0; g < 8; g++) begin
            w = {3'h0, g[2:0], 6'($urandom), 12'h013 + 12'($urandom_range(12'h7BD))};
            wr(1'b0, w, 24, 0);
            note(pk(w, 1'b1), obs());
            rd(1'b0, 24, w);
        end
        wr(1'b0, 24'h3C07D0, 16, 0);
        rd(1'b0, 24, w);
        w = 24'h140013;
        wr(1'b0, w, 24, 6);
        rd(1'b0, 24, w);
        $display("test control done");
        for (int k = 0; k < 4; k++) begin
            w = {6'h00, 2'b00, k[0], 2'b00, k[1], 12'h7D0};
            wr(1'b0, w, 24, 0);
            r = 24'($urandom);
            conv(r);
            note(pk(w, 1'b0), obs());
            e = k[1] ? r : r ^ adc_ctrl_pkg::OFFSET_FLIP;
            rd(1'b1, k[0] ? 24 : 16, k[0] ? e : {8'h00, e[23:8]});
            note(pk(w, 1'b1), obs());
        end
        $display("test data done");
        for (int m = 6; m < 8; m++) begin
            for (int c = 0; c < 2; c++) begin
                coef(m[2:0], c[0], (m == 6) ? 24'h000000 : 24'h800000);
                r = 24'($urandom);
                wr(1'b1, r, 24, 0);
                rd(1'b1, 24, r);
                wr(1'b1, ~r, 16, 0);
                rd(1'b1, 24, r);
            end
        end
        $display("test coefficients done");
        // Each calibration mode on the second input
        for (int m = 1; m < 5; m++) begin
            wr(1'b0, {m[2:0], 3'h0, 1'b1, 5'h00, 12'h0C8}, 24, 0);
            note(32'h00000001, {31'h0, calBusy});
            for (int s = 0; s < ((m == 1 || m == 4) ? 2 : 1); s++) begin
                e = (s == 1) ? 24'(adc_ctrl_pkg::SRC_REFERENCE) : (m == 1) ?
                    24'(adc_ctrl_pkg::SRC_SHORTED) : 24'(adc_ctrl_pkg::SRC_INPUT);
                note({8'h00, e}, {30'h0, frontSource});
                r = 24'($urandom);
                if (m == 3 || s == 1) fr = r;
                else zr = r;
                conv(r);
            end
            note(pk(24'h0200C8, 1'b0), obs());
            rd(1'b0, 24, 24'h0200C8);
        end
        coef(3'h6, 1'b1, zr);
        coef(3'h7, 1'b1, fr);
        $display("test calibration done");
        wr(1'b0, {3'h5, 3'h0, 1'b0, 5'h00, 12'h0C8}, 24, 0);
        for (int s = 0; s < 6; s++) begin
            e = (s == 0) ? 24'(adc_ctrl_pkg::SRC_SHORTED) : (s == 1) ?
                24'(adc_ctrl_pkg::SRC_REFERENCE) : 24'(adc_ctrl_pkg::SRC_INPUT);
            note({8'h00, e}, {30'h0, frontSource});
            r = 24'($urandom);
            if (s == 0) zr = r;
            if (s == 1) fr = r;
            conv(r);
            note({31'h0, s != 5}, {31'h0, dataReadyN});
        end
        coef(3'h6, 1'b0, zr);
        coef(3'h7, 1'b0, fr);
        $display("test background done");
        results();
    end
endmodule : test_adc_control_word_calibration_sequencer
bind adc_control_sequencer adc_control_sequencer_assertions chk_u (.clk(clk), .rst(rst),
    .tfsN(tfsN), .rfsN(rfsN), .sdataOe(sdataOe), .dataReadyN(dataReadyN),
    .convDone(convDone), .activeChannel(activeChannel), .gainCode(gainCode),
    .gainFactor(gainFactor), .filterCode(filterCode), .filterCodeLegal(filterCodeLegal),
    .filterRestart(filterRestart), .calBusy(calBusy));

// *** src/adc_control_sequencer.sv ***
module adc_control_sequencer #(
    parameter int CHANNELS = 2,
    parameter int BG_SLOTS = adc_ctrl_pkg::BG_SLOTS
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic sclk,
    input wire logic tfsN,
    input wire logic rfsN,
    input wire logic registerSelectLine,
    input wire logic sdataIn,
    output logic sdataOut,
    output logic sdataOe,
    output logic dataReadyN,
    input wire logic convDone,
    input wire logic [23:0] convRaw,
    output adc_ctrl_pkg::front_src_t frontSource,
    output logic activeChannel,
    output logic [2:0] gainCode,
    output logic [7:0] gainFactor,
    output logic powerDown,
    output logic compCurrent,
    output logic burnoutCurrent,
    output logic unipolar,
    output logic [11:0] filterCode,
    output logic filterCodeLegal,
    output logic filterRestart,
    output logic calBusy
);
    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (CHANNELS != 2) begin : g_chan_check
        $error("CHANNELS must be 2: one channel select bit");
    end
    if (BG_SLOTS < 3 || BG_SLOTS > 7) begin : g_slot_check
        $error("BG_SLOTS must lie between 3 and 7");
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PH_IDLE,
        PH_ZERO,
        PH_FULL
    } cal_phase_t;

    typedef struct packed {
        logic [23:0] control;
        logic [CHANNELS-1:0][23:0] zeroCoef;
        logic [CHANNELS-1:0][23:0] fullCoef;
        logic [23:0] dataWord;
        logic [23:0] readWord;
        logic readLen24;
        logic ready;
        cal_phase_t phase;
        logic [2:0] bgSlot;
        logic [2:0] wrSync;
        logic [2:0] rdSync;
        logic [1:0] rfsSync;
        logic [1:0] selSync;
        logic restart;
    } state_t;

    state_t s;
    state_t next_s;

    logic [23:0] linkWord;
    logic linkSel;
    logic linkWriteDone;
    logic linkReadDone;

    // ------------------------------------------------------------
    // Serial port on the link clock
    // ------------------------------------------------------------
    adc_serial_link u_link (
        .sclk(sclk),
        .tfsN(tfsN),
        .rfsN(rfsN),
        .registerSelectLine(registerSelectLine),
        .sdataIn(sdataIn),
        .sdataOut(sdataOut),
        .sdataOe(sdataOe),
        .readWord(s.readWord),
        .readLen24(s.readLen24),
        .writeWord(linkWord),
        .frameSel(linkSel),
        .writeDone(linkWriteDone),
        .readDone(linkReadDone)
    );

    // ------------------------------------------------------------
    // Decoded control fields
    // ------------------------------------------------------------
    adc_ctrl_pkg::op_mode_t mode;
    logic chan;
    logic wrEvent;
    logic rdEvent;
    logic readBusy;
    logic addrHigh;
    logic [2:0] lastSlot;

    assign mode = adc_ctrl_pkg::op_mode_t'(
        s.control[adc_ctrl_pkg::MODE_HI:adc_ctrl_pkg::MODE_LO]);
    assign chan = s.control[adc_ctrl_pkg::CHAN_BIT];
    assign lastSlot = 3'(BG_SLOTS - 1);

    // Only the second and third sync stages are looked at
    assign wrEvent = s.wrSync[1] & ~s.wrSync[2];
    assign rdEvent = s.rdSync[1] & ~s.rdSync[2];
    assign readBusy = ~s.rfsSync[1];
    assign addrHigh = s.selSync[1];

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic [23:0] coded;
        logic held;
        logic fresh;
        coded = '0;
        held = 1'b0;
        fresh = 1'b0;
        next_s = s;
        next_s.restart = 1'b0;
        next_s.wrSync = {s.wrSync[1:0], linkWriteDone};
        next_s.rdSync = {s.rdSync[1:0], linkReadDone};
        next_s.rfsSync = {s.rfsSync[0], rfsN};
        next_s.selSync = {s.selSync[0], registerSelectLine};

        // Offset binary for bipolar, natural binary for unipolar
        coded = s.control[adc_ctrl_pkg::POL_BIT] ? convRaw
                                                 : convRaw ^ adc_ctrl_pkg::OFFSET_FLIP;

        // A completed data read in normal or background mode releases the ready line
        if (rdEvent && linkSel && (mode == adc_ctrl_pkg::MODE_NORMAL ||
                                   mode == adc_ctrl_pkg::MODE_BACKGROUND)) begin
            next_s.ready = 1'b0;
        end

        // Conversion results; a new word set after the clear wins
        held = next_s.ready;
        next_s.ready = 1'b0;
        if (convDone && !s.control[adc_ctrl_pkg::PDOWN_BIT]) begin
            unique case (s.phase)
                PH_IDLE: begin
                    if (mode == adc_ctrl_pkg::MODE_BACKGROUND) begin
                        if (s.bgSlot == 3'h0) begin
                            next_s.zeroCoef[chan] = convRaw;
                        end else if (s.bgSlot == 3'h1) begin
                            next_s.fullCoef[chan] = convRaw;
                        end else if (s.bgSlot == lastSlot) begin
                            next_s.dataWord = coded;
                            next_s.ready = 1'b1;
                        end
                        next_s.bgSlot = (s.bgSlot == lastSlot) ? 3'h0 : s.bgSlot + 3'h1;
                        next_s.restart = 1'b1;
                    end else begin
                        next_s.dataWord = coded;
                        next_s.ready = 1'b1;
                    end
                end
                PH_ZERO: begin
                    next_s.zeroCoef[chan] = convRaw;
                    next_s.restart = 1'b1;
                    if (mode == adc_ctrl_pkg::MODE_SELF_CAL ||
                        mode == adc_ctrl_pkg::MODE_SYS_OFFSET) begin
                        next_s.phase = PH_FULL;
                    end else begin
                        // Step done: back to normal with ready low
                        next_s.phase = PH_IDLE;
                        next_s.control[adc_ctrl_pkg::MODE_HI:adc_ctrl_pkg::MODE_LO] =
                            adc_ctrl_pkg::MODE_NORMAL;
                        next_s.ready = 1'b1;
                    end
                end
                PH_FULL: begin
                    next_s.fullCoef[chan] = convRaw;
                    next_s.restart = 1'b1;
                    next_s.phase = PH_IDLE;
                    next_s.control[adc_ctrl_pkg::MODE_HI:adc_ctrl_pkg::MODE_LO] =
                        adc_ctrl_pkg::MODE_NORMAL;
                    next_s.ready = 1'b1;
                end
            endcase
        end
        fresh = next_s.ready;
        next_s.ready = next_s.ready | held;

        // Writes from the host; only complete 24-bit words ever arrive here
        if (wrEvent && !linkSel) begin
            next_s.control = linkWord;
            next_s.bgSlot = 3'h0;
            next_s.restart = 1'b1;
            // Clears ready unless a word lands in this same cycle
            next_s.ready = fresh;
            unique case (adc_ctrl_pkg::op_mode_t'(
                linkWord[adc_ctrl_pkg::MODE_HI:adc_ctrl_pkg::MODE_LO]))
                adc_ctrl_pkg::MODE_SELF_CAL,
                adc_ctrl_pkg::MODE_SYS_ZERO,
                adc_ctrl_pkg::MODE_SYS_OFFSET: next_s.phase = PH_ZERO;
                adc_ctrl_pkg::MODE_SYS_FULL: next_s.phase = PH_FULL;
                adc_ctrl_pkg::MODE_NORMAL,
                adc_ctrl_pkg::MODE_BACKGROUND,
                adc_ctrl_pkg::MODE_ZERO_COEF,
                adc_ctrl_pkg::MODE_FULL_COEF: next_s.phase = PH_IDLE;
            endcase
        end else if (wrEvent && linkSel) begin
            if (mode == adc_ctrl_pkg::MODE_ZERO_COEF) begin
                next_s.zeroCoef[chan] = linkWord;
            end else if (mode == adc_ctrl_pkg::MODE_FULL_COEF) begin
                next_s.fullCoef[chan] = linkWord;
            end
        end

        // Read snapshot stays frozen while a read frame is open
        if (!readBusy) begin
            if (!addrHigh) begin
                next_s.readWord = s.control;
                next_s.readLen24 = 1'b1;
            end else if (mode == adc_ctrl_pkg::MODE_ZERO_COEF) begin
                next_s.readWord = s.zeroCoef[chan];
                next_s.readLen24 = 1'b1;
            end else if (mode == adc_ctrl_pkg::MODE_FULL_COEF) begin
                next_s.readWord = s.fullCoef[chan];
                next_s.readLen24 = 1'b1;
            end else begin
                next_s.readWord = s.dataWord;
                next_s.readLen24 = s.control[adc_ctrl_pkg::WLEN_BIT];
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            s <= '0;
            s.control <= adc_ctrl_pkg::CONTROL_RESET;
            s.zeroCoef <= {CHANNELS{adc_ctrl_pkg::ZERO_COEF_RESET}};
            s.fullCoef <= {CHANNELS{adc_ctrl_pkg::FULL_COEF_RESET}};
            s.phase <= PH_IDLE;
            s.wrSync <= 3'h0;
            s.rdSync <= 3'h0;
            s.rfsSync <= 2'h3;
            s.selSync <= 2'h0;
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------
    // Front-end and filter controls
    // ------------------------------------------------------------
    always_comb begin
        frontSource = adc_ctrl_pkg::SRC_INPUT;
        unique case (s.phase)
            PH_ZERO: begin
                if (mode == adc_ctrl_pkg::MODE_SELF_CAL) begin
                    frontSource = adc_ctrl_pkg::SRC_SHORTED;
                end
            end
            PH_FULL: begin
                if (mode == adc_ctrl_pkg::MODE_SELF_CAL ||
                    mode == adc_ctrl_pkg::MODE_SYS_OFFSET) begin
                    frontSource = adc_ctrl_pkg::SRC_REFERENCE;
                end
            end
            PH_IDLE: begin
                if (mode == adc_ctrl_pkg::MODE_BACKGROUND) begin
                    if (s.bgSlot == 3'h0) begin
                        frontSource = adc_ctrl_pkg::SRC_SHORTED;
                    end else if (s.bgSlot == 3'h1) begin
                        frontSource = adc_ctrl_pkg::SRC_REFERENCE;
                    end
                end
            end
        endcase
    end

    assign activeChannel = chan;
    assign gainCode = s.control[adc_ctrl_pkg::GAIN_HI:adc_ctrl_pkg::GAIN_LO];
    assign gainFactor = adc_ctrl_pkg::GAIN_ONE << gainCode;
    assign powerDown = s.control[adc_ctrl_pkg::PDOWN_BIT];
    assign compCurrent = s.control[adc_ctrl_pkg::COMP_BIT];
    assign burnoutCurrent = s.control[adc_ctrl_pkg::BURN_BIT];
    assign unipolar = s.control[adc_ctrl_pkg::POL_BIT];
    assign filterCode = s.control[adc_ctrl_pkg::FILT_HI:adc_ctrl_pkg::FILT_LO];
    // Out-of-range codes are the host's fault; flagged, not corrected
    assign filterCodeLegal = (filterCode >= adc_ctrl_pkg::FILTER_MIN) &&
                             (filterCode <= adc_ctrl_pkg::FILTER_MAX);
    assign filterRestart = s.restart;
    assign calBusy = (s.phase != PH_IDLE);
    assign dataReadyN = ~s.ready;

endmodule : adc_control_sequencer

// *** src/adc_ctrl_pkg.sv ***
// How it works
// - Mode 000 normal, address-high reads return conversion data
// - Mode 001 self-calibrates, then mode clears
// - Ready output flags each calibration command done
// - Mode 010 zero-scale on input, then normal
// - Mode 011 full-scale on input, then normal
// - Mode 100 input zero, reference full, normal
// - Mode 101 background, word rate divided six
// - Background keeps channel coefficients updated automatically
// - Mode 110 address-high accesses zero coefficient
// - Mode 111 address-high accesses full coefficient
// - Coefficient transfers always use 24 bits
// - Short coefficient writes are discarded
// - Gain equals two to gain code
// - Control loads only after 24 bits
// - Word-length bit picks 16 or 24 bits
// - Polarity bit picks offset or natural binary
package adc_ctrl_pkg;

    // ------------------------------------------------------------
    // Word and field layout
    // ------------------------------------------------------------
    localparam int WORD_BITS = 24;
    localparam logic [4:0] WORD_CNT = 5'h18;
    localparam logic [4:0] SHORT_CNT = 5'h10;
    localparam int MODE_HI = 23;
    localparam int MODE_LO = 21;
    localparam int GAIN_HI = 20;
    localparam int GAIN_LO = 18;
    localparam int CHAN_BIT = 17;
    localparam int PDOWN_BIT = 16;
    localparam int WLEN_BIT = 15;
    localparam int COMP_BIT = 14;
    localparam int BURN_BIT = 13;
    localparam int POL_BIT = 12;
    localparam int FILT_HI = 11;
    localparam int FILT_LO = 0;

    // ------------------------------------------------------------
    // Reset values and codes
    // ------------------------------------------------------------
    localparam logic [11:0] FILTER_RESET = 12'h0C8;
    localparam logic [23:0] CONTROL_RESET = {12'h000, FILTER_RESET};
    localparam logic [23:0] ZERO_COEF_RESET = 24'h000000;
    localparam logic [23:0] FULL_COEF_RESET = 24'h800000;
    localparam logic [23:0] OFFSET_FLIP = 24'h800000;
    localparam logic [11:0] FILTER_MIN = 12'h013;
    localparam logic [11:0] FILTER_MAX = 12'h7D0;
    localparam logic [7:0] GAIN_ONE = 8'h01;
    localparam int BG_SLOTS = 6;

    typedef enum logic [2:0] {
        MODE_NORMAL = 3'h0,
        MODE_SELF_CAL = 3'h1,
        MODE_SYS_ZERO = 3'h2,
        MODE_SYS_FULL = 3'h3,
        MODE_SYS_OFFSET = 3'h4,
        MODE_BACKGROUND = 3'h5,
        MODE_ZERO_COEF = 3'h6,
        MODE_FULL_COEF = 3'h7
    } op_mode_t;

    typedef enum logic [1:0] {
        SRC_INPUT,
        SRC_SHORTED,
        SRC_REFERENCE
    } front_src_t;

endpackage : adc_ctrl_pkg

// *** src/adc_serial_link.sv ***
module adc_serial_link (
    input wire logic sclk,
    input wire logic tfsN,
    input wire logic rfsN,
    input wire logic registerSelectLine,
    input wire logic sdataIn,
    output logic sdataOut,
    output logic sdataOe,
    input wire logic [23:0] readWord,
    input wire logic readLen24,
    output logic [23:0] writeWord,
    output logic frameSel,
    output logic writeDone,
    output logic readDone
);
    // ------------------------------------------------------------
    // Link state: control part ends with the frame
    // ------------------------------------------------------------
    typedef struct packed {
        logic [4:0] bitCnt;
        logic writeDone;
        logic readDone;
        logic sel;
    } frame_t;

    typedef struct packed {
        logic [23:0] shiftIn;
        logic [23:0] shiftOut;
    } shift_t;

    frame_t f;
    frame_t next_f;
    shift_t d;
    shift_t next_d;
    logic frameIdle;
    logic [4:0] readLen;

    // The serial clock stops between frames, so the idle level clears the counters
    assign frameIdle = tfsN & rfsN;
    assign readLen = readLen24 ? adc_ctrl_pkg::WORD_CNT : adc_ctrl_pkg::SHORT_CNT;

    always_comb begin
        next_f = f;
        next_d = d;
        if (!tfsN) begin
            // Clocks after the 24th fall through and are ignored
            if (f.bitCnt < adc_ctrl_pkg::WORD_CNT) begin
                next_d.shiftIn = {d.shiftIn[22:0], sdataIn};
                next_f.bitCnt = f.bitCnt + 5'h01;
                if (f.bitCnt == adc_ctrl_pkg::WORD_CNT - 5'h01) begin
                    next_f.writeDone = 1'b1;
                    next_f.sel = registerSelectLine;
                end
            end
        end else if (!rfsN) begin
            if (f.bitCnt < readLen) begin
                next_d.shiftOut = (f.bitCnt == 5'h00) ? {readWord[22:0], 1'b0}
                                                      : {d.shiftOut[22:0], 1'b0};
                next_f.bitCnt = f.bitCnt + 5'h01;
                if (f.bitCnt == readLen - 5'h01) begin
                    next_f.readDone = 1'b1;
                    next_f.sel = registerSelectLine;
                end
            end
        end
    end

    always_ff @(posedge sclk or posedge frameIdle) begin
        if (frameIdle) begin
            f <= '0;
        end else begin
            f <= next_f;
        end
    end

    always_ff @(posedge sclk) begin
        d <= next_d;
    end

    assign sdataOut = (f.bitCnt == 5'h00) ? readWord[23] : d.shiftOut[23];
    assign sdataOe = !rfsN && tfsN && (f.bitCnt < readLen);
    assign writeWord = d.shiftIn;
    assign frameSel = f.sel;
    assign writeDone = f.writeDone;
    assign readDone = f.readDone;

endmodule : adc_serial_link
